/* oda_decoder.sv */
// oda_decoder: fetches opcode and operand bytes, decodes, paces cycles.
// assumes program memory on ref_clk; config and bank inputs on ref_clk.
// Contract
// - fetch 8-bit opcode, decide operand bytes
// - three-bit field picks bank register 0-7
// - direct 0-127 data memory, 128-255 registers
// - indirect address from register zero or one
// - immediates from stream, 8 or 16 bit
// - long jump/call carry full 16-bit target
// - page target keeps next instruction's 2k page
// - relative displacement added to next address
// - bit operand addresses one bit directly
// - one cycle is 12 or 6 clocks
// - increment forms; pointer increment two cycles
// - decrement forms decoded, one cycle each
// - multiply and divide: one byte, four cycles
// - decimal adjust: one byte, one cycle
// - and forms; direct-immediate form two cycles
// - or forms; direct-immediate form two cycles
// - xor forms; direct-immediate form two cycles
// - moves into accumulator, one cycle each
// - timing select: 12 clocks set, 6 cleared
`timescale 1ns/1ps
module oda_decoder (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic doubleSpeedTimingSelect,
    input wire logic [1:0] bankSel,
    output logic [15:0] pmAddr,
    output logic pmRd,
    input wire logic [7:0] pmData,
    input wire logic pmValid,
    output logic instrValid,
    output oda_pkg::oda_instr_t instr,
    output oda_pkg::oda_operand_t operand
);
    import oda_pkg::*;

    // one-hot sequencer states
    typedef enum logic [2:0] {
        ST_FETCH = 3'b001,
        ST_OPER = 3'b010,
        ST_EXEC = 3'b100
    } oda_state_t;

    // clocks taken by a number of machine cycles
    function automatic logic [5:0] mcClocks(input logic [2:0] mc,
                                            input logic is12);
        mcClocks = 6'(mc * (is12 ? CLK_MC_12T : CLK_MC_6T));
    endfunction : mcClocks

    // opcode to class, mode, length and machine cycles
    function automatic oda_dec_t decodeOp(input logic [7:0] op);
        oda_dec_t d;
        oda_op_t fam;
        d.opClass = OP_BAD;
        d.mode = MD_NONE;
        d.len = 2'd1;
        d.mcyc = 3'd1;
        // families sharing the low-nibble operand layout
        case (op[7:4])
            NIB_INC: fam = OP_INC;
            NIB_DEC: fam = OP_DEC;
            NIB_ADD: fam = OP_ADD;
            NIB_ADDC: fam = OP_ADDC;
            NIB_SUBB: fam = OP_SUBB;
            NIB_ANL: fam = OP_ANL;
            NIB_ORL: fam = OP_ORL;
            NIB_XRL: fam = OP_XRL;
            NIB_MOVA: fam = OP_MOVA;
            default: fam = OP_BAD;
        endcase
        if (fam != OP_BAD && op[3:0] >= LO_IMM) begin
            d.opClass = fam;
            if (op[3:0] >= LO_REG) begin
                d.mode = MD_REG;
            end else if (op[3:0] >= LO_IND) begin
                d.mode = MD_IND;
            end else if (op[3:0] == LO_DIR) begin
                d.mode = MD_DIR;
                d.len = 2'd2;
            end else begin
                d.mode = MD_IMM;
                d.len = 2'd2;
            end
        end
        // logic ops writing a direct byte
        if (fam == OP_ANL || fam == OP_ORL || fam == OP_XRL) begin
            if (op[3:0] == LO_DIRA) begin
                d.opClass = fam;
                d.mode = MD_DIRA;
                d.len = 2'd2;
            end else if (op[3:0] == LO_DIRIMM) begin
                d.opClass = fam;
                d.mode = MD_DIRIMM;
                d.len = 2'd3;
                d.mcyc = 3'd2;
            end
        end
        // page jump and call share eight opcodes each
        if (op[4:0] == LO5_AJMP || op[4:0] == LO5_ACALL) begin
            d.opClass = op[4] ? OP_ACALL : OP_AJMP;
            d.mode = MD_PAGE;
            d.len = 2'd2;
            d.mcyc = 3'd2;
        end
        // single opcodes override the family layout
        case (op)
            OPC_NOP: d.opClass = OP_NOP;
            OPC_INC_A, OPC_DEC_A: begin
                d.mode = MD_ACC;
                d.len = 2'd1;
            end
            OPC_INC_PTR16: begin
                d.opClass = OP_INC_PTR16;
                d.mcyc = 3'd2;
            end
            OPC_MUL, OPC_DIV: begin
                d.opClass = op[5] ? OP_MUL : OP_DIV;
                d.mcyc = 3'd4;
            end
            OPC_DA: d.opClass = OP_DA;
            OPC_CLR: begin
                d.opClass = OP_CLR;
                d.mode = MD_NONE;
                d.len = 2'd1;
            end
            OPC_CPL: d.opClass = OP_CPL;
            OPC_RL: d.opClass = OP_RL;
            OPC_RLC: d.opClass = OP_RLC;
            OPC_RR: d.opClass = OP_RR;
            OPC_RRC: d.opClass = OP_RRC;
            OPC_SWAP: d.opClass = OP_SWAP;
            OPC_MOVA_IMM: begin
                d.opClass = OP_MOVA;
                d.mode = MD_IMM;
                d.len = 2'd2;
            end
            OPC_MOV_PTR16: begin
                d.opClass = OP_MOV_PTR16;
                d.mode = MD_IMM16;
                d.len = 2'd3;
                d.mcyc = 3'd2;
            end
            OPC_LJMP, OPC_LCALL: begin
                d.opClass = op[4] ? OP_LCALL : OP_LJMP;
                d.mode = MD_LONG;
                d.len = 2'd3;
                d.mcyc = 3'd2;
            end
            OPC_SJMP, OPC_JZ, OPC_JNZ, OPC_JC, OPC_JNC: begin
                d.opClass = (op == OPC_SJMP) ? OP_SJMP : OP_JCOND;
                d.mode = MD_REL;
                d.len = 2'd2;
                d.mcyc = 3'd2;
            end
            OPC_JB, OPC_JNB: begin
                d.opClass = OP_JBIT;
                d.mode = MD_BITREL;
                d.len = 2'd3;
                d.mcyc = 3'd2;
            end
            default: d.opClass = d.opClass;
        endcase
        decodeOp = d;
    endfunction : decodeOp

    oda_state_t state_r, state_nxt; // sequencer
    logic [15:0] pc_r, pc_nxt; // next byte to fetch
    oda_instr_t instr_r, instr_nxt; // instruction being fetched
    logic [1:0] byteIdx_r, byteIdx_nxt; // bytes taken so far
    logic [5:0] cnt_r, cnt_nxt; // clocks left before retire
    oda_operand_t operand_r, operand_nxt; // resolved operands
    oda_operand_t opdComb; // resolver output
    oda_dec_t decNow; // decode of the byte on the bus
    logic latchOpd; // last byte taken this cycle

    assign decNow = decodeOp(pmData);

    // address resolution after the program counter passed all bytes
    oda_operand_resolve u_resolve (
        .instr(instr_nxt),
        .pcAfter(pc_nxt),
        .bankSel(bankSel),
        .operand(opdComb)
    );

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        instr_nxt = instr_r;
        byteIdx_nxt = byteIdx_r;
        cnt_nxt = (cnt_r != 6'd0) ? cnt_r - 6'd1 : cnt_r;
        latchOpd = 1'b0;
        pmRd = 1'b0;
        case (state_r)
            ST_FETCH: begin
                pmRd = ce;
                if (pmValid) begin
                    // opcode taken; budget fixed by the timing select
                    instr_nxt.dec = decNow;
                    instr_nxt.opcode = pmData;
                    instr_nxt.op1 = 8'h00;
                    instr_nxt.op2 = 8'h00;
                    pc_nxt = pc_r + 16'd1;
                    byteIdx_nxt = 2'd1;
                    cnt_nxt = mcClocks(decNow.mcyc, doubleSpeedTimingSelect)
                              - CNT_OVERHEAD;
                    if (decNow.len == 2'd1) begin
                        state_nxt = ST_EXEC;
                        latchOpd = 1'b1;
                    end else begin
                        state_nxt = ST_OPER;
                    end
                end
            end
            ST_OPER: begin
                pmRd = ce;
                if (pmValid) begin
                    // operand bytes in stream order
                    if (byteIdx_r == 2'd1) begin
                        instr_nxt.op1 = pmData;
                    end else begin
                        instr_nxt.op2 = pmData;
                    end
                    pc_nxt = pc_r + 16'd1;
                    byteIdx_nxt = byteIdx_r + 2'd1;
                    if (byteIdx_nxt == instr_r.dec.len) begin
                        state_nxt = ST_EXEC;
                        latchOpd = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                // hold until the cycle budget is spent
                if (cnt_r == 6'd0) begin
                    state_nxt = ST_FETCH;
                end
            end
            default: begin
                state_nxt = ST_FETCH;
            end
        endcase
    end

    // operands held until the last byte of the next instruction
    assign operand_nxt = latchOpd ? opdComb : operand_r;

    // sequencer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_FETCH;
            pc_r <= PC_RESET;
            instr_r <= '0;
            byteIdx_r <= 2'd0;
            cnt_r <= 6'd0;
            operand_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            instr_r <= instr_nxt;
            byteIdx_r <= byteIdx_nxt;
            cnt_r <= cnt_nxt;
            operand_r <= operand_nxt;
        end
    end

    // outputs
    assign pmAddr = pc_r;
    assign instr = instr_r;
    assign operand = operand_r;
    assign instrValid = ce && (state_r == ST_EXEC) && (cnt_r == 6'd0);

    // checking helpers: span since opcode, stall seen, start address
    logic [5:0] span_r, span_nxt;
    logic stall_r, stall_nxt;
    logic [15:0] startPc_r, startPc_nxt;
    logic selTake_r, selTake_nxt; // timing select seen at opcode take
    logic take;
    always_comb begin
        take = (state_r == ST_FETCH) && pmValid;
        span_nxt = take ? 6'd0 : span_r + 6'd1;
        stall_nxt = take ? 1'b0 :
                    (stall_r || ((state_r == ST_OPER) && !pmValid));
        startPc_nxt = take ? pc_r : startPc_r;
        selTake_nxt = take ? doubleSpeedTimingSelect : selTake_r;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            span_r <= 6'd0;
            stall_r <= 1'b0;
            startPc_r <= PC_RESET;
            selTake_r <= 1'b0;
        end else if (ce) begin
            span_r <= span_nxt;
            stall_r <= stall_nxt;
            startPc_r <= startPc_nxt;
            selTake_r <= selTake_nxt;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence retire(logic [7:0] opc);
        instrValid && instr_r.opcode == opc;
    endsequence

    pc_step_a: assert property (
        instrValid |-> pc_r == startPc_r + 16'(instr_r.dec.len))
        else $error("pc did not pass exactly the instruction bytes");
    clk_span_a: assert property (
        (instrValid && !stall_r) |->
        span_r == mcClocks(instr_r.dec.mcyc, selTake_r) - CNT_OVERHEAD)
        else $error("instruction span differs from cycle budget");
    one_byte_a: assert property (
        (ce && state_r == ST_FETCH && pmValid && decNow.len == 2'd1)
        |=> state_r == ST_EXEC ##0 !pmRd)
        else $error("one-byte opcode fetched an operand");
    nop_form_a: assert property (
        retire(OPC_NOP) |-> instr_r.dec.opClass == OP_NOP
        && instr_r.dec.len == 2'd1 && instr_r.dec.mcyc == 3'd1)
        else $error("no-op not one byte one cycle");
    mul_div_a: assert property (
        (retire(OPC_MUL) or retire(OPC_DIV)) |->
        instr_r.dec.mcyc == 3'd4 && instr_r.dec.len == 2'd1)
        else $error("multiply or divide cycle count wrong");
    ptr_inc_a: assert property (
        retire(OPC_INC_PTR16) |-> instr_r.dec.mcyc == 3'd2)
        else $error("pointer increment not two cycles");
    and_dirimm_a: assert property (
        instrValid && instr_r.opcode == 8'h53 |->
        instr_r.dec.len == 2'd3 && instr_r.dec.mcyc == 3'd2)
        else $error("and direct-immediate form wrong");
    add_forms_a: assert property (
        instrValid && instr_r.opcode[7:4] == NIB_ADD
        && instr_r.opcode[3:0] >= LO_IMM |->
        instr_r.dec.opClass == OP_ADD && instr_r.dec.mcyc == 3'd1)
        else $error("add form misdecoded");
    dir_space_a: assert property (
        instrValid && instr_r.dec.mode == MD_DIR |->
        operand_r.dirIsSfr == operand_r.dirAddr[7]
        && operand_r.dirAddr == instr_r.op1)
        else $error("direct space split wrong");
    ind_ptr_a: assert property (
        instrValid && instr_r.dec.mode == MD_IND |->
        operand_r.regAddr[2:0] == {2'b00, instr_r.opcode[0]})
        else $error("pointer register select wrong");
    rel_tgt_a: assert property (
        instrValid && instr_r.dec.mode == MD_REL |->
        operand_r.target == pc_r + {{8{instr_r.op1[7]}}, instr_r.op1})
        else $error("relative target wrong");
    page_tgt_a: assert property (
        instrValid && instr_r.dec.mode == MD_PAGE |->
        operand_r.target[15:11] == pc_r[15:11]
        && operand_r.target[10:0] == {instr_r.opcode[7:5], instr_r.op1})
        else $error("page target left the page");

    mul_seen_c: cover property (retire(OPC_MUL));
    long_seen_c: cover property (instrValid
        && instr_r.dec.mode == MD_LONG);
    fast_seen_c: cover property (instrValid && !doubleSpeedTimingSelect);
    three_byte_c: cover property (instrValid && instr_r.dec.len == 2'd3);

endmodule : oda_decoder

/* oda_pkg.sv */
// oda_pkg: shared constants, enums and carriers for the opcode decoder.
// assumes one 200 MHz ref_clk domain; program memory answers byte reads.
package oda_pkg;

    // program counter after reset
    localparam logic [15:0] PC_RESET = 16'h0000;
    // oscillator clocks in one machine cycle
    localparam logic [5:0] CLK_MC_12T = 6'h0C;
    localparam logic [5:0] CLK_MC_6T = 6'h06;
    // fetch cycle plus retire cycle come off the machine-cycle budget
    localparam logic [5:0] CNT_OVERHEAD = 6'h02;
    // direct space split between data memory and function registers
    localparam logic [7:0] DIR_IRAM_MAX = 8'h7F;
    // byte base of bit-addressable data memory, upper nibble
    localparam logic [3:0] BIT_IRAM_BASE = 4'h2;

    // single opcodes
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_INC_A = 8'h04;
    localparam logic [7:0] OPC_DEC_A = 8'h14;
    localparam logic [7:0] OPC_INC_PTR16 = 8'hA3;
    localparam logic [7:0] OPC_MUL = 8'hA4;
    localparam logic [7:0] OPC_DIV = 8'h84;
    localparam logic [7:0] OPC_DA = 8'hD4;
    localparam logic [7:0] OPC_CLR = 8'hE4;
    localparam logic [7:0] OPC_CPL = 8'hF4;
    localparam logic [7:0] OPC_RL = 8'h23;
    localparam logic [7:0] OPC_RLC = 8'h33;
    localparam logic [7:0] OPC_RR = 8'h03;
    localparam logic [7:0] OPC_RRC = 8'h13;
    localparam logic [7:0] OPC_SWAP = 8'hC4;
    localparam logic [7:0] OPC_MOVA_IMM = 8'h74;
    localparam logic [7:0] OPC_MOV_PTR16 = 8'h90;
    localparam logic [7:0] OPC_LJMP = 8'h02;
    localparam logic [7:0] OPC_LCALL = 8'h12;
    localparam logic [7:0] OPC_SJMP = 8'h80;
    localparam logic [7:0] OPC_JZ = 8'h60;
    localparam logic [7:0] OPC_JNZ = 8'h70;
    localparam logic [7:0] OPC_JC = 8'h40;
    localparam logic [7:0] OPC_JNC = 8'h50;
    localparam logic [7:0] OPC_JB = 8'h20;
    localparam logic [7:0] OPC_JNB = 8'h30;
    // page jump and call: low five opcode bits
    localparam logic [4:0] LO5_AJMP = 5'h01;
    localparam logic [4:0] LO5_ACALL = 5'h11;

    // family high nibbles
    localparam logic [3:0] NIB_INC = 4'h0;
    localparam logic [3:0] NIB_DEC = 4'h1;
    localparam logic [3:0] NIB_ADD = 4'h2;
    localparam logic [3:0] NIB_ADDC = 4'h3;
    localparam logic [3:0] NIB_ORL = 4'h4;
    localparam logic [3:0] NIB_ANL = 4'h5;
    localparam logic [3:0] NIB_XRL = 4'h6;
    localparam logic [3:0] NIB_SUBB = 4'h9;
    localparam logic [3:0] NIB_MOVA = 4'hE;
    // family low nibbles
    localparam logic [3:0] LO_DIRA = 4'h2;
    localparam logic [3:0] LO_DIRIMM = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_IND = 4'h6;
    localparam logic [3:0] LO_REG = 4'h8;

    // operation classes
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADDC, OP_SUBB, OP_INC, OP_DEC, OP_INC_PTR16,
        OP_MUL, OP_DIV, OP_DA, OP_ANL, OP_ORL, OP_XRL, OP_CLR, OP_CPL,
        OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP, OP_MOVA, OP_MOV_PTR16,
        OP_AJMP, OP_ACALL, OP_LJMP, OP_LCALL, OP_SJMP, OP_JCOND, OP_JBIT,
        OP_BAD
    } oda_op_t;

    // operand addressing modes
    typedef enum logic [3:0] {
        MD_NONE, MD_ACC, MD_REG, MD_IND, MD_DIR, MD_IMM, MD_IMM16,
        MD_DIRA, MD_DIRIMM, MD_PAGE, MD_LONG, MD_REL, MD_BITREL
    } oda_mode_t;

    // decode result of one opcode
    typedef struct packed {
        oda_op_t opClass;
        oda_mode_t mode;
        logic [1:0] len;
        logic [2:0] mcyc;
    } oda_dec_t;

    // fetched instruction
    typedef struct packed {
        oda_dec_t dec;
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
    } oda_instr_t;

    // resolved operands
    typedef struct packed {
        logic [7:0] regAddr;
        logic [7:0] dirAddr;
        logic dirIsSfr;
        logic [7:0] imm8;
        logic [15:0] imm16;
        logic [7:0] bitAddr;
        logic [15:0] target;
        logic hasTarget;
    } oda_operand_t;

endpackage : oda_pkg

/* oda_operand_resolve.sv */
// oda_operand_resolve: turns opcode and operand bytes into addresses.
// purely combinational; pcAfter must already point past the instruction.
`timescale 1ns/1ps
module oda_operand_resolve (
    input oda_pkg::oda_instr_t instr,
    input wire logic [15:0] pcAfter,
    input wire logic [1:0] bankSel,
    output oda_pkg::oda_operand_t operand
);
    import oda_pkg::*;

    // relative target from a signed displacement
    function automatic logic [15:0] relTarget(input logic [15:0] pc,
                                              input logic [7:0] disp);
        relTarget = pc + {{8{disp[7]}}, disp};
    endfunction : relTarget

    // direct byte above the data-memory range is a function register
    function automatic logic isSfr(input logic [7:0] addr);
        isSfr = (addr > DIR_IRAM_MAX);
    endfunction : isSfr

    // operand fields by mode
    always_comb begin
        operand = '0;
        case (instr.dec.mode)
            MD_REG: begin
                operand.regAddr = {3'b000, bankSel, instr.opcode[2:0]};
            end
            MD_IND: begin
                // pointer register zero or one of the bank
                operand.regAddr = {3'b000, bankSel, 2'b00, instr.opcode[0]};
            end
            MD_DIR, MD_DIRA: begin
                operand.dirAddr = instr.op1;
                operand.dirIsSfr = isSfr(instr.op1);
            end
            MD_DIRIMM: begin
                operand.dirAddr = instr.op1;
                operand.dirIsSfr = isSfr(instr.op1);
                operand.imm8 = instr.op2;
            end
            MD_IMM: begin
                operand.imm8 = instr.op1;
            end
            MD_IMM16: begin
                operand.imm16 = {instr.op1, instr.op2};
            end
            MD_LONG: begin
                // full 64k reach, high byte first
                operand.target = {instr.op1, instr.op2};
                operand.hasTarget = 1'b1;
            end
            MD_PAGE: begin
                // stays in the 2k page of the next instruction
                operand.target = {pcAfter[15:11], instr.opcode[7:5],
                                  instr.op1};
                operand.hasTarget = 1'b1;
            end
            MD_REL: begin
                operand.target = relTarget(pcAfter, instr.op1);
                operand.hasTarget = 1'b1;
            end
            MD_BITREL: begin
                // bit address and the byte holding it
                operand.bitAddr = instr.op1;
                operand.dirIsSfr = isSfr(instr.op1);
                operand.dirAddr = isSfr(instr.op1) ?
                    {instr.op1[7:3], 3'b000} :
                    {BIT_IRAM_BASE, instr.op1[6:3]};
                operand.target = relTarget(pcAfter, instr.op2);
                operand.hasTarget = 1'b1;
            end
            default: begin
                operand.hasTarget = 1'b0;
            end
        endcase
    end

endmodule : oda_operand_resolve

/* oda_prog_mem.sv */
// oda_prog_mem: behavioural program memory facing the decoder.
// assumes reads on ref_clk; the bench loads mem before reset ends.
`timescale 1ns/1ps
module oda_prog_mem (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic pmRd,
    input wire logic [15:0] pmAddr,
    output logic [7:0] pmData,
    output logic pmValid
);
    logic [7:0] mem [0:1023]; // program image
    logic readyRnd_r = 1'b1; // random answer gate in slow mode
    logic [7:0] junk_r = 8'h00; // moving filler while not answering
    // pick this cycle's readiness, roll the filler
    always @(posedge ref_clk) begin
        readyRnd_r <= ($urandom % 3) == 0;
        junk_r <= junk_r + 8'h53;
    end
    // answer at once, or late when slow
    assign pmValid = pmRd & (~slow | readyRnd_r);
    assign pmData = pmValid ? mem[pmAddr[9:0]] : junk_r;
endmodule : oda_prog_mem

/* opcode_decode_arith_logic_bench.sv */
// opcode_decode_arith_logic_bench: random program checked by a model.
// assumes oda_pkg, oda_decoder and oda_prog_mem compiled first.
`timescale 1ns/1ps
module opcode_decode_arith_logic_bench;
    import oda_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic doubleSpeedTimingSelect = 1'b1;
    logic [1:0] bankSel = 2'h0;
    logic slow = 1'b0; // memory stalls and ce drops when set
    logic [15:0] pmAddr;
    logic pmRd, pmValid, instrValid;
    logic [7:0] pmData, b1, b2;
    oda_instr_t instr;
    oda_operand_t operand;
    int n_fail = 0;
    int checks = 0;
    int expQ[$]; // opcode, op1, op2 of coming retires
    int cyc = 0, lastRet = 0, nRet = 0, skip = 1, pcm = 0;
    int e, op, ln, hi, lo, a, t, w;
    initial forever #2.5 ref_clk = ~ref_clk;
    oda_decoder oda_decoder_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .doubleSpeedTimingSelect(doubleSpeedTimingSelect),
        .bankSel(bankSel), .pmAddr(pmAddr), .pmRd(pmRd), .pmData(pmData),
        .pmValid(pmValid), .instrValid(instrValid), .instr(instr),
        .operand(operand));
    oda_prog_mem oda_prog_mem_inst (.ref_clk(ref_clk), .slow(slow),
        .pmRd(pmRd), .pmAddr(pmAddr), .pmData(pmData), .pmValid(pmValid));
    function automatic int lenOf(input int o);
        if (o inside {2, 'h12, 'h20, 'h30, 'h43, 'h53, 'h63, 'h90}) return 3;
        if ((o & 15) == 5 || o == 'h42 || o == 'h52 || o == 'h62) return 2;
        if ((o & 15) == 1 || o inside {'h40, 'h50, 'h60, 'h70, 'h80}) return 2;
        if ((o & 15) == 4 && o >= 'h24 && o <= 'h94 && o != 'h84) return 2;
        return 1;
    endfunction : lenOf
    function automatic int mcOf(input int o);
        if (o == 'hA4 || o == 'h84) return 4;
        if (o == 'hA3 || lenOf(o) == 3 || (o & 15) == 1) return 2;
        if (o inside {'h40, 'h50, 'h60, 'h70, 'h80}) return 2;
        return 1;
    endfunction : mcOf
    function automatic bit okOp(input int o);
        if ((o & 15) >= 4 && (o < 'h70 || o >> 4 == 9 || o >> 4 == 14))
            return 1;
        return (o & 15) == 1 || o inside {0, 2, 3, 'h12, 'h13, 'h20, 'h23,
            'h30, 'h33, 'h40, 'h42, 'h43, 'h50, 'h52, 'h53, 'h60, 'h62,
            'h63, 'h70, 'h74, 'h80, 'h84, 'h90, 'hA3, 'hA4, 'hC4, 'hD4,
            'hF4};
    endfunction : okOp
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // ce drops at random in the stalling phase
    always @(posedge ref_clk) ce <= ~slow | ($urandom % 8 != 0);
    // model comparison at every retire
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (!rst && instrValid === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            op = e & 255;
            b1 = 8'(e >> 8);
            b2 = 8'(e >> 16);
            ln = lenOf(op);
            hi = op >> 4;
            lo = op & 15;
            a = mcOf(op) * (doubleSpeedTimingSelect ? 12 : 6);
            chk(16'(instr.opcode), 16'(op));
            chk(16'(instr.dec.len), 16'(ln));
            chk(16'(instr.dec.mcyc), 16'(mcOf(op)));
            if (ln > 1) chk(16'(instr.op1), 16'(b1));
            if (ln > 2) chk(16'(instr.op2), 16'(b2));
            pcm = pcm + ln;
            chk(pmAddr, 16'(pcm));
            if (op == 'h90) chk(operand.imm16, {b1, b2});
            if (op == 2 || op == 'h12) chk(operand.target, {b1, b2});
            if ((op & 15) == 1) chk(operand.target,
                16'(pcm & 'hF800 | (op >> 5) << 8 | b1));
            if (op inside {'h40, 'h50, 'h60, 'h70, 'h80})
                chk(operand.target, 16'(pcm + $signed(b1)));
            if (op == 'h20 || op == 'h30)
                chk(operand.target, 16'(pcm + $signed(b2)));
            if (op == 'h20 || op == 'h30)
                chk(16'(operand.bitAddr), 16'(b1));
            if (skip == 0) begin
                t = cyc - lastRet;
                if (!slow) chk(16'(t), 16'(a));
                else chk(16'(t >= a), 16'h0001);
                if (lo >= 8)
                    chk(16'(operand.regAddr), 16'({bankSel, op[2:0]}));
                if (lo == 6 || lo == 7)
                    chk(16'(operand.regAddr), 16'({bankSel, 2'b0, op[0]}));
                if (lo == 5 || ((lo == 2 || lo == 3) && hi > 3))
                    chk({operand.dirIsSfr, operand.dirAddr}, {b1[7], b1});
                if (lo == 4 && ln == 2) chk(16'(operand.imm8), 16'(b1));
            end
            if (skip > 0) skip = skip - 1;
            lastRet = cyc;
            nRet++;
        end
    end
    // build the program, then run three timing and stall phases
    initial begin
        a = $urandom(65804);
        for (a = 0; a < 1024; a++) oda_prog_mem_inst.mem[a] = 8'h00;
        a = 0;
        repeat (120) begin
            do op = $urandom % 256; while (!okOp(op));
            b1 = 8'($urandom);
            b2 = 8'($urandom);
            oda_prog_mem_inst.mem[a] = 8'(op);
            oda_prog_mem_inst.mem[a + 1] = b1;
            oda_prog_mem_inst.mem[a + 2] = b2;
            a = a + lenOf(op);
            expQ.push_back(op | int'(b1) << 8 | int'(b2) << 16);
        end
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            if (p > 0) begin
                doubleSpeedTimingSelect <= (p == 2);
                slow <= (p == 2);
                bankSel <= 2'($urandom);
                skip = 2;
            end
            for (w = 0; w < 30000 && nRet < 40 * (p + 1); w++)
                @(posedge ref_clk);
            if (nRet < 40 * (p + 1)) begin
                n_fail++;
                break;
            end
            @(posedge ref_clk);
        end
        end_sim();
    end
endmodule : opcode_decode_arith_logic_bench
